// ===== hw/dfae_engine.sv
// Register-driven file access engine with APB slave and transfer window.
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module dfae_engine
    import dfae_pkg::*;
#(
    parameter int          WIN_AW     = 8,
    parameter int          FILE_AW    = 10,
    parameter logic [15:0] TARGET_MAP = 16'h3fff,
    parameter logic [15:0] LOCKED_MAP = 16'h0040
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    output logic             device_restart_command,
    output logic             boot_image_pending,
    output logic             lut_load_strobe,
    output logic             busy
);

    localparam int CW = FILE_AW + 1;
    localparam logic [CW-1:0] WIN_CAP = CW'(1 << WIN_AW);

    // ****************************************************************
    // Types and state
    // ****************************************************************
    typedef enum logic [1:0] {
        DFAE_S_IDLE = 2'b00,
        DFAE_S_COPY = 2'b01,
        DFAE_S_WAIT = 2'b10,
        DFAE_S_DONE = 2'b11
    } dfae_state_e;

    dfae_state_e   state_reg;
    logic [3:0]    target_reg;
    logic [2:0]    op_reg;
    logic          mode_reg;
    logic [FILE_AW-1:0] start_reg;
    logic [CW-1:0] count_reg;
    logic [1:0]    outcome_reg;
    logic [CW-1:0] xfer_reg;
    logic [15:0]   open_reg;
    logic [15:0]   open_dir_reg;
    logic [15:0]   exist_reg;
    logic [CW-1:0] size_reg [0:15];
    logic [WIN_AW-1:0] win_ptr_reg;
    logic [CW-1:0] idx_reg;
    logic [CW-1:0] len_reg;
    logic          dir_reg;
    logic [7:0]    win_rdata;
    logic [7:0]    file_rdata;
    logic [DFAE_IRQ_W-1:0] irq_status;
    logic [DFAE_IRQ_W-1:0] irq_mask;

    function automatic logic [CW-1:0] dfae_min(input logic [CW-1:0] a, input logic [CW-1:0] b);
        dfae_min = (a < b) ? a : b;
    endfunction : dfae_min

    // ****************************************************************
    // APB decode
    // ****************************************************************
    wire acc      = psel && penable;
    wire wr_acc   = acc && pwrite;
    wire known    = (paddr[1:0] == 2'b00) && (paddr <= DFAE_RESTART_OFS);
    wire wr_target = wr_acc && (paddr == DFAE_TARGET_OFS) && !busy;
    wire wr_op    = wr_acc && (paddr == DFAE_OP_OFS) && !busy;
    wire wr_mode  = wr_acc && (paddr == DFAE_MODE_OFS) && !busy;
    wire wr_start = wr_acc && (paddr == DFAE_START_OFS) && !busy;
    wire wr_count = wr_acc && (paddr == DFAE_COUNT_OFS) && !busy;
    wire wr_ptr   = wr_acc && (paddr == DFAE_WIN_PTR_OFS) && !busy;
    wire wr_wdata = wr_acc && (paddr == DFAE_WIN_DATA_OFS) && !busy;
    wire rd_wdata = acc && !pwrite && (paddr == DFAE_WIN_DATA_OFS);
    wire trigger  = wr_acc && (paddr == DFAE_EXEC_OFS) && pwdata[DFAE_EXEC_BIT] && !busy;
    wire wr_irqs  = wr_acc && (paddr == DFAE_IRQ_STAT_OFS);
    wire wr_irqm  = wr_acc && (paddr == DFAE_IRQ_MASK_OFS);

    // Window data reads take two cycles because the buffer read is registered.
    logic rd_wait_reg;
    assign pready  = !rd_wdata || rd_wait_reg;
    assign pslverr = acc && pready && !known;
    assign busy    = (state_reg != DFAE_S_IDLE);

    // ****************************************************************
    // Operation decode
    // ****************************************************************
    wire [3:0]    tsel      = target_reg;
    wire          t_exists  = exist_reg[tsel];
    wire          t_locked  = LOCKED_MAP[tsel];
    wire          t_open    = open_reg[tsel];
    wire          t_dir     = open_dir_reg[tsel];
    wire [CW-1:0] t_size    = size_reg[tsel];
    wire [CW-1:0] start_w   = CW'(start_reg);
    wire [CW-1:0] file_left = (start_w < t_size) ? (t_size - start_w) : '0;
    wire [CW-1:0] file_cap  = CW'(1 << FILE_AW);
    wire [CW-1:0] wr_left   = (start_w < file_cap) ? (file_cap - start_w) : '0;
    wire [CW-1:0] read_len  = dfae_min(dfae_min(count_reg, WIN_CAP), file_left);
    wire [CW-1:0] write_len = dfae_min(dfae_min(count_reg, WIN_CAP), wr_left);
    wire          is_rd     = (op_reg == DFAE_OP_READ);
    wire          is_wr     = (op_reg == DFAE_OP_WRITE);
    wire          is_open   = (op_reg == DFAE_OP_OPEN);
    wire          rd_ok     = t_open && (t_dir == DFAE_DIR_READ);
    wire          wr_ok     = t_open && (t_dir == DFAE_DIR_WRITE);
    wire          op_legal  = (op_reg <= DFAE_OP_DEL);

    // Immediate outcome for operations that need no byte copy.
    logic [1:0] imm_outcome;
    always_comb
    begin
        imm_outcome = DFAE_OUT_SUCCESS;
        if (!t_exists && !(is_open && mode_reg == DFAE_DIR_WRITE))
            imm_outcome = DFAE_OUT_ABSENT;
        else if (!TARGET_MAP[tsel] || !op_legal)
            imm_outcome = DFAE_OUT_ABSENT;
        else if (t_locked && (is_wr || op_reg == DFAE_OP_DEL || (is_open && mode_reg)))
            imm_outcome = DFAE_OUT_NOACC;
        else if ((is_rd && !rd_ok) || (is_wr && !wr_ok))
            imm_outcome = DFAE_OUT_FAIL;
        else if (is_open && t_open)
            imm_outcome = DFAE_OUT_NOACC;
        else if ((op_reg == DFAE_OP_CLOSE && !t_open) || (op_reg == DFAE_OP_DEL && t_open))
            imm_outcome = DFAE_OUT_FAIL;
    end

    wire need_copy = (imm_outcome == DFAE_OUT_SUCCESS) && (is_rd || is_wr);

    // ****************************************************************
    // Transfer window and file storage
    // ****************************************************************
    wire               cp_valid = (state_reg == DFAE_S_WAIT);
    wire [WIN_AW-1:0]  cp_widx  = WIN_AW'(idx_reg);
    wire [FILE_AW-1:0] cp_fidx  = FILE_AW'(start_w + idx_reg);

    // One storage array holds every target; each target owns one region.
    localparam int MEM_AW = FILE_AW + 4;
    wire               win_we   = wr_wdata || (cp_valid && dir_reg == DFAE_DIR_READ);
    wire [WIN_AW-1:0]  win_addr = busy ? cp_widx : win_ptr_reg;
    wire [7:0]         win_wd   = busy ? file_rdata : pwdata[7:0];
    wire               file_we  = cp_valid && dir_reg == DFAE_DIR_WRITE;
    wire [MEM_AW-1:0]  file_addr = {tsel, cp_fidx};

    dfae_mem #(.AW(WIN_AW)) u_window
    (
        .pclk  (pclk),
        .we    (win_we),
        .addr  (win_addr),
        .wdata (win_wd),
        .rdata (win_rdata)
    );

    dfae_mem #(.AW(MEM_AW)) u_store
    (
        .pclk  (pclk),
        .we    (file_we),
        .addr  (file_addr),
        .wdata (win_rdata),
        .rdata (file_rdata)
    );

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    wire cp_last = (idx_reg + CW'(1) >= len_reg);
    wire done    = (state_reg == DFAE_S_DONE);
    wire t_write_done = done && dir_reg == DFAE_DIR_WRITE && len_reg != '0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= DFAE_S_IDLE;
            idx_reg   <= '0;
            len_reg   <= '0;
            dir_reg   <= DFAE_DIR_READ;
        end
        else
        begin
            unique case (state_reg)
                DFAE_S_IDLE:
                begin
                    idx_reg <= '0;
                    dir_reg <= is_wr;
                    len_reg <= is_rd ? read_len : write_len;
                    if (trigger && need_copy)
                    begin
                        state_reg <= (is_rd ? read_len : write_len) == '0 ? DFAE_S_DONE
                                                                         : DFAE_S_COPY;
                    end
                end
                DFAE_S_COPY: state_reg <= DFAE_S_WAIT;
                DFAE_S_WAIT:
                begin
                    idx_reg   <= idx_reg + CW'(1);
                    state_reg <= cp_last ? DFAE_S_DONE : DFAE_S_COPY;
                end
                DFAE_S_DONE: state_reg <= DFAE_S_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Control and result registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            target_reg   <= DFAE_TARGET_RST;
            op_reg       <= DFAE_OP_OPEN;
            mode_reg     <= DFAE_DIR_READ;
            start_reg    <= '0;
            count_reg    <= '0;
            win_ptr_reg  <= '0;
            outcome_reg  <= DFAE_OUT_SUCCESS;
            xfer_reg     <= '0;
            open_reg     <= '0;
            open_dir_reg <= '0;
            rd_wait_reg  <= 1'b0;
        end
        else
        begin
            rd_wait_reg <= rd_wdata && !rd_wait_reg;
            if (wr_target) target_reg <= pwdata[3:0];
            if (wr_op)     op_reg     <= pwdata[2:0];
            if (wr_mode)   mode_reg   <= pwdata[0];
            if (wr_start)  start_reg  <= pwdata[FILE_AW-1:0];
            if (wr_count)  count_reg  <= pwdata[CW-1:0];
            if (wr_ptr || (rd_wdata && rd_wait_reg) || wr_wdata)
            begin
                win_ptr_reg <= wr_ptr ? pwdata[WIN_AW-1:0] : win_ptr_reg + WIN_AW'(1);
            end
            if (trigger && !need_copy)
            begin
                outcome_reg <= imm_outcome;
                xfer_reg    <= '0;
                if (imm_outcome == DFAE_OUT_SUCCESS && op_reg == DFAE_OP_OPEN)
                begin
                    open_reg[tsel]     <= 1'b1;
                    open_dir_reg[tsel] <= mode_reg;
                end
                if (imm_outcome == DFAE_OUT_SUCCESS && op_reg == DFAE_OP_CLOSE)
                begin
                    open_reg[tsel] <= 1'b0;
                end
            end
            if (done)
            begin
                outcome_reg <= DFAE_OUT_SUCCESS;
                xfer_reg    <= len_reg;
            end
        end
    end

    // Sizes grow with writes that extend a file; deletes empty it.
    wire [CW-1:0] wr_end = start_w + len_reg;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            exist_reg <= TARGET_MAP & ~16'h1000;
            for (int i = 0; i < 16; i++)
                size_reg[i] <= '0;
        end
        else if (trigger && op_reg == DFAE_OP_DEL && imm_outcome == DFAE_OUT_SUCCESS)
        begin
            size_reg[tsel]  <= '0;
            exist_reg[tsel] <= (tsel == DFAE_T_PIC) ? 1'b0 : 1'b1;
        end
        else if (t_write_done)
        begin
            exist_reg[tsel] <= 1'b1;
            if (wr_end > t_size) size_reg[tsel] <= wr_end;
        end
    end

    // ****************************************************************
    // Side effects, interrupts and read mux
    // ****************************************************************
    logic lut_reg;
    logic boot_reg;
    logic restart_reg;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lut_reg     <= 1'b0;
            boot_reg    <= 1'b0;
            restart_reg <= 1'b0;
        end
        else
        begin
            lut_reg     <= t_write_done && tsel == DFAE_T_LUT;
            boot_reg    <= boot_reg || (t_write_done && tsel == DFAE_T_BOOT);
            restart_reg <= wr_acc && paddr == DFAE_RESTART_OFS && pwdata[0];
        end
    end
    assign lut_load_strobe        = lut_reg;
    assign boot_image_pending     = boot_reg;
    assign device_restart_command = restart_reg;

    wire op_end = done || (trigger && !need_copy);
    wire [DFAE_IRQ_W-1:0] evts = {lut_reg,
                                  trigger && !need_copy && imm_outcome != DFAE_OUT_SUCCESS,
                                  op_end};

    dfae_irq u_irq
    (
        .pclk       (pclk),
        .presetn    (presetn),
        .events     (evts),
        .clear      (wr_irqs ? pwdata[DFAE_IRQ_W-1:0] : '0),
        .mask_we    (wr_irqm),
        .mask_wdata (pwdata[DFAE_IRQ_W-1:0]),
        .status_reg (irq_status),
        .mask_reg   (irq_mask),
        .irq        (irq)
    );

    always_comb
    begin
        prdata = '0;
        unique case (paddr)
            DFAE_TARGET_OFS:   prdata = 32'(target_reg);
            DFAE_OP_OFS:       prdata = 32'(op_reg);
            DFAE_MODE_OFS:     prdata = 32'(mode_reg);
            DFAE_EXEC_OFS:     prdata = 32'(busy);
            DFAE_START_OFS:    prdata = 32'(start_reg);
            DFAE_COUNT_OFS:    prdata = 32'(count_reg);
            DFAE_OUTCOME_OFS:  prdata = 32'(outcome_reg);
            DFAE_XFER_OFS:     prdata = 32'(xfer_reg);
            DFAE_TOTAL_OFS:    prdata = 32'(t_size);
            DFAE_IRQ_STAT_OFS: prdata = 32'(irq_status);
            DFAE_IRQ_MASK_OFS: prdata = 32'(irq_mask);
            DFAE_WIN_PTR_OFS:  prdata = 32'(win_ptr_reg);
            DFAE_WIN_DATA_OFS: prdata = 32'(win_rdata);
            default:           prdata = '0;
        endcase
    end

endmodule : dfae_engine

// ===== hw/dfae_pkg.sv
// Package of constants and types for the device file access engine.
package dfae_pkg;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] DFAE_TARGET_OFS  = 8'h00;
    localparam logic [7:0] DFAE_OP_OFS      = 8'h04;
    localparam logic [7:0] DFAE_MODE_OFS    = 8'h08;
    localparam logic [7:0] DFAE_EXEC_OFS    = 8'h0c;
    localparam logic [7:0] DFAE_START_OFS   = 8'h10;
    localparam logic [7:0] DFAE_COUNT_OFS   = 8'h14;
    localparam logic [7:0] DFAE_OUTCOME_OFS = 8'h18;
    localparam logic [7:0] DFAE_XFER_OFS    = 8'h1c;
    localparam logic [7:0] DFAE_TOTAL_OFS   = 8'h20;
    localparam logic [7:0] DFAE_IRQ_STAT_OFS = 8'h24;
    localparam logic [7:0] DFAE_IRQ_MASK_OFS = 8'h28;
    localparam logic [7:0] DFAE_WIN_PTR_OFS = 8'h2c;
    localparam logic [7:0] DFAE_WIN_DATA_OFS = 8'h30;
    localparam logic [7:0] DFAE_RESTART_OFS = 8'h34;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int DFAE_EXEC_BIT    = 0;
    localparam int DFAE_IRQ_DONE    = 0;
    localparam int DFAE_IRQ_FAIL    = 1;
    localparam int DFAE_IRQ_LUT     = 2;
    localparam int DFAE_IRQ_W       = 3;
    localparam logic [3:0]  DFAE_TARGET_RST = 4'h0;
    localparam logic [31:0] DFAE_ZERO_RST   = 32'h0000_0000;
    localparam int DFAE_CYC_PER_BYTE = 1;

    typedef enum logic [3:0] {
        DFAE_T_BOOT  = 4'h0,
        DFAE_T_SET1  = 4'h1,
        DFAE_T_SET2  = 4'h2,
        DFAE_T_SET3  = 4'h3,
        DFAE_T_SET4  = 4'h4,
        DFAE_T_LUT   = 4'h5,
        DFAE_T_FUNI  = 4'h6,
        DFAE_T_UUNI1 = 4'h7,
        DFAE_T_UUNI2 = 4'h8,
        DFAE_T_UUNI3 = 4'h9,
        DFAE_T_UUNI4 = 4'ha,
        DFAE_T_CMAT  = 4'hb,
        DFAE_T_PIC   = 4'hc,
        DFAE_T_LIC   = 4'hd
    } dfae_target_e;

    typedef enum logic [2:0] {
        DFAE_OP_OPEN  = 3'h0,
        DFAE_OP_CLOSE = 3'h1,
        DFAE_OP_READ  = 3'h2,
        DFAE_OP_WRITE = 3'h3,
        DFAE_OP_DEL   = 3'h4
    } dfae_op_e;

    typedef enum logic [1:0] {
        DFAE_OUT_SUCCESS = 2'h0,
        DFAE_OUT_FAIL    = 2'h1,
        DFAE_OUT_NOACC   = 2'h2,
        DFAE_OUT_ABSENT  = 2'h3
    } dfae_outcome_e;

    localparam logic DFAE_DIR_READ  = 1'b0;
    localparam logic DFAE_DIR_WRITE = 1'b1;

endpackage : dfae_pkg

// ===== hw/dfae_mem.sv
// Single-port byte memory with registered read data.
`timescale 1ns/1ps
module dfae_mem
    import dfae_pkg::*;
#(
    parameter int AW = 10
)
(
    input  wire logic          pclk,
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    output logic      [7:0]    rdata
);

    logic [7:0] mem [0:(1<<AW)-1];

    always_ff @(posedge pclk)
    begin
        if (we)
        begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end

endmodule : dfae_mem

// ===== hw/dfae_irq.sv
// Sticky interrupt status with write-one-to-clear and mask.
`timescale 1ns/1ps
module dfae_irq
    import dfae_pkg::*;
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic [DFAE_IRQ_W-1:0] events,
    input  wire logic [DFAE_IRQ_W-1:0] clear,
    input  wire logic                mask_we,
    input  wire logic [DFAE_IRQ_W-1:0] mask_wdata,
    output logic      [DFAE_IRQ_W-1:0] status_reg,
    output logic      [DFAE_IRQ_W-1:0] mask_reg,
    output logic                     irq
);

    // A new event wins over a clear in the same cycle.
    wire [DFAE_IRQ_W-1:0] status_next = (status_reg & ~clear) | events;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_reg <= '0;
            mask_reg   <= '0;
        end
        else
        begin
            status_reg <= status_next;
            if (mask_we)
            begin
                mask_reg <= mask_wdata;
            end
        end
    end

    assign irq = |(status_reg & mask_reg);

endmodule : dfae_irq

// ===== verification/dfae_checker.sv
// Port-level assertions for the file access engine.
`timescale 1ns/1ps
module dfae_checker
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        device_restart_command,
    input wire logic        boot_image_pending,
    input wire logic        lut_load_strobe,
    input wire logic        busy
);
    // ****************************************************************
    // Bus and engine properties
    // ****************************************************************
    wire acc = psel && penable;
    wire bad = (paddr[1:0] != 2'h0) || (paddr > 8'h34);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_bad_flagged: assert property (acc && bad |-> pslverr)
        else $error("Unmapped access not flagged.");
    a_good_clean: assert property (acc && !bad |-> !pslverr)
        else $error("Mapped access flagged.");
    a_unmap_zero: assert property (acc && !pwrite && bad |-> prdata == 32'h0)
        else $error("Unmapped read data not zero.");
    a_ready_fast: assert property (acc && paddr != 8'h30 |-> pready)
        else $error("Register access stalled.");
    a_window_wait: assert property (psel && !penable && !pwrite && paddr == 8'h30
        |=> !pready ##1 pready)
        else $error("Window read wait state wrong.");
    a_restart_pulse: assert property (acc && pready && pwrite && paddr == 8'h34
        && pwdata[0] |=> device_restart_command ##1 !device_restart_command)
        else $error("Restart pulse wrong.");
    a_boot_hold: assert property (boot_image_pending |=> boot_image_pending)
        else $error("Pending boot image dropped.");
    a_lut_pulse: assert property (lut_load_strobe |=> !lut_load_strobe)
        else $error("Table load strobe too long.");
    a_select_idle: assert property (!busy && !(acc && pwrite && paddr == 8'h0c)
        |=> !busy)
        else $error("Engine started without trigger.");
    a_busy_ends: assert property ($rose(busy) |-> ##[1:600] !busy)
        else $error("Engine never completed.");
endmodule : dfae_checker

bind dfae_engine dfae_checker u_dfae_checker (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .device_restart_command,
    .boot_image_pending, .lut_load_strobe, .busy);

// ===== verification/tb_top.sv
// Self-checking testbench for the file access engine.
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top
    import dfae_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, busy, rerr;
    logic        device_restart_command, boot_image_pending, lut_load_strobe;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [7:0]  bf [64];
    int          seed, error_cnt, tests_run, lut_cnt, rs_cnt, n;

    dfae_engine u_dfae_engine (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .irq, .device_restart_command, .boot_image_pending,
        .lut_load_strobe, .busy);

    // ****************************************************************
    // Tasks and expectations
    // ****************************************************************
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // A poke lands while the engine copies, so it must be ignored.
    task automatic run(input logic [31:0] op, input bit poke);
        apb(1'b1, DFAE_OP_OFS, op);
        apb(1'b1, DFAE_EXEC_OFS, 32'h1);
        if (poke)
            apb(1'b1, DFAE_COUNT_OFS, 32'h1);
        @(posedge pclk);
        while (busy !== 1'b0)
            @(posedge pclk);
    endtask : run

    task automatic sel(input int t, input logic [31:0] m);
        apb(1'b1, DFAE_TARGET_OFS, 32'(t));
        apb(1'b1, DFAE_MODE_OFS, m);
    endtask : sel

    function automatic logic [31:0] exp_open(input int t);
        return (t > 13 || t == 12) ? 32'h3 : 32'h0;
    endfunction : exp_open

    function automatic logic [31:0] lmin(input int c, input int l);
        return 32'((c < l) ? c : l);
    endfunction : lmin

    task print_verdict;
        if (error_cnt == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict

    // ****************************************************************
    // Clock, monitors and watchdog
    // ****************************************************************
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        lut_cnt += lut_load_strobe;
        rs_cnt += device_restart_command;
    end

    initial
    begin
        repeat (50000) @(posedge pclk);
        error_cnt++;
        print_verdict();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        seed = 73597;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, DFAE_OUTCOME_OFS, 32'h0);
        `CHK(rdat, 32'h0)
        apb(1'b0, 8'h38, 32'h0);
        `CHK(rdat, 32'h0)
        `CHK(rerr, 1'b1)
        for (int t = 0; t < 16; t++)
        begin
            sel(t, DFAE_DIR_READ);
            run(DFAE_OP_OPEN, 0);
            apb(1'b0, DFAE_OUTCOME_OFS, 32'h0);
            `CHK(rdat, exp_open(t))
            if (rdat == 32'h0)
                run(DFAE_OP_CLOSE, 0);
        end
        sel(1, DFAE_DIR_WRITE);
        run(DFAE_OP_READ, 0);
        apb(1'b0, DFAE_OUTCOME_OFS, 32'h0);
        `CHK(rdat, 32'h1)
        sel(6, DFAE_DIR_WRITE);
        run(DFAE_OP_OPEN, 0);
        apb(1'b0, DFAE_OUTCOME_OFS, 32'h0);
        `CHK(rdat, 32'h2)
        sel(1, DFAE_DIR_WRITE);
        run(DFAE_OP_OPEN, 0);
        n = 8 + ($random(seed) & 31);
        apb(1'b1, DFAE_WIN_PTR_OFS, 32'h0);
        for (int i = 0; i < n; i++)
        begin
            bf[i] = 8'($random(seed));
            apb(1'b1, DFAE_WIN_DATA_OFS, {24'h0, bf[i]});
        end
        apb(1'b1, DFAE_START_OFS, 32'h0);
        apb(1'b1, DFAE_COUNT_OFS, 32'(n));
        run(DFAE_OP_WRITE, 0);
        apb(1'b0, DFAE_XFER_OFS, 32'h0);
        `CHK(rdat, 32'(n))
        apb(1'b0, DFAE_TOTAL_OFS, 32'h0);
        `CHK(rdat, 32'(n))
        `CHK(irq, 1'b0)
        apb(1'b1, DFAE_IRQ_MASK_OFS, 32'h1);
        `CHK(irq, 1'b1)
        apb(1'b1, DFAE_IRQ_STAT_OFS, 32'h1);
        `CHK(irq, 1'b0)
        run(DFAE_OP_CLOSE, 0);
        sel(1, DFAE_DIR_READ);
        run(DFAE_OP_OPEN, 0);
        run(DFAE_OP_OPEN, 0);
        apb(1'b0, DFAE_OUTCOME_OFS, 32'h0);
        `CHK(rdat, 32'h2)
        run(DFAE_OP_WRITE, 0);
        apb(1'b0, DFAE_OUTCOME_OFS, 32'h0);
        `CHK(rdat, 32'h1)
        apb(1'b1, DFAE_START_OFS, 32'h2);
        apb(1'b1, DFAE_COUNT_OFS, 32'd300);
        apb(1'b1, DFAE_WIN_PTR_OFS, 32'h0);
        run(DFAE_OP_READ, 1);
        apb(1'b0, DFAE_COUNT_OFS, 32'h0);
        `CHK(rdat, 32'd300)
        apb(1'b0, DFAE_XFER_OFS, 32'h0);
        `CHK(rdat, lmin(300, 32'(lmin(256, n - 2))))
        apb(1'b1, DFAE_WIN_PTR_OFS, 32'h0);
        for (int i = 0; i < n - 2; i++)
        begin
            apb(1'b0, DFAE_WIN_DATA_OFS, 32'h0);
            `CHK(rdat[7:0], bf[i + 2])
        end
        run(DFAE_OP_CLOSE, 0);
        for (int t = 0; t < 6; t += 5)
        begin
            sel(t, DFAE_DIR_WRITE);
            run(DFAE_OP_OPEN, 0);
            apb(1'b1, DFAE_START_OFS, 32'h0);
            apb(1'b1, DFAE_COUNT_OFS, 32'h4);
            run(DFAE_OP_WRITE, 0);
            run(DFAE_OP_CLOSE, 0);
        end
        `CHK(lut_cnt, 1)
        `CHK(boot_image_pending, 1'b1)
        `CHK(rs_cnt, 0)
        apb(1'b1, DFAE_TARGET_OFS, 32'h1);
        run(DFAE_OP_DEL, 0);
        apb(1'b0, DFAE_TOTAL_OFS, 32'h0);
        `CHK(rdat, 32'h0)
        run(32'h5, 0);
        apb(1'b0, DFAE_OUTCOME_OFS, 32'h0);
        `CHK(rdat, 32'h3)
        sel(12, DFAE_DIR_WRITE);
        run(DFAE_OP_OPEN, 0);
        apb(1'b0, DFAE_OUTCOME_OFS, 32'h0);
        `CHK(rdat, 32'h0)
        apb(1'b1, DFAE_RESTART_OFS, 32'h1);
        @(posedge pclk);
        `CHK(rs_cnt, 1)
        print_verdict();
    end
endmodule : tb_top
